//--- cms_defs.vh
`ifndef CMS_DEFS_VH
`define CMS_DEFS_VH

`define CMS_IDX_W         5
`define CMS_IDX_SP        5'h0D
`define CMS_IDX_LR        5'h0E
`define CMS_IDX_PC        5'h0F
`define CMS_IDX_HI_FIRST  5'h08
`define CMS_NUM_GPR       13

`define CMS_ADDR_GPR_BASE 12'h000
`define CMS_ADDR_MAIN_SP  12'h040
`define CMS_ADDR_PROC_SP  12'h044
`define CMS_ADDR_LINK     12'h048
`define CMS_ADDR_PC       12'h04C
`define CMS_ADDR_PSR      12'h050
`define CMS_ADDR_APP      12'h054
`define CMS_ADDR_INT      12'h058
`define CMS_ADDR_EXE      12'h05C
`define CMS_ADDR_PRIORITY_MASK_BIT  12'h060
`define CMS_ADDR_FLTMASK  12'h064
`define CMS_ADDR_BASE_PRIORITY_THRESHOLD  12'h068
`define CMS_ADDR_CTRL     12'h06C
`define CMS_ADDR_CORE     12'h070
`define CMS_ADDR_EXC      12'h074
`define CMS_ADDR_CALL     12'h078
`define CMS_ADDR_FAULT    12'h07C
`define CMS_ADDR_IRQ      12'h080
`define CMS_ADDR_STATUS   12'h084

`define CMS_APP_MASK      32'hF8000000
`define CMS_INT_MASK      32'h000001FF
`define CMS_EXE_MASK      32'h0600FC00
`define CMS_TBIT          24
`define CMS_SP_ALIGN      32'hFFFFFFFC
`define CMS_PC_ALIGN      32'hFFFFFFFE
`define CMS_EXC_W         9
`define CMS_BP_W          9
`define CMS_EXC_NMI       9'h002
`define CMS_EXC_HARD      9'h003
`define CMS_CTRL_USER     0
`define CMS_CTRL_SPSEL    1

`define CMS_HTRANS_NONSEQ 2'h2
`define CMS_HSIZE_WORD    3'h2

`endif

//--- cms_core_regs.v
`timescale 1ns/1ps
// Function
// - Handler mode exists only when privileged
// - User level blocks special access, raises fault; code blocks only writes to PSR through CTRL, reads pass
// - Handler while servicing exception, else thread
// - All core registers 32 bits, low regs universal
// - High registers blocked for 16-bit encodings; code faults only for indexes 8-12, not SP, LR, PC
// - Banked stack pointer: process for thread if selected
// - Stack pointer low two bits read zero
// - Subroutine call stores return address in link
// - Program counter bit zero reads zero
// - Status readable combined or as three parts
// - Application flags live in bits 27-31
// - Interrupt part holds exception number 0-8
// - Execution part holds bits 10-15, 25-26
// - State bit 24 reads one; clearing faults
// - Priority mask passes only NMI, hard fault
// - Fault mask passes only NMI
// - Nonzero base priority blocks equal or lower
// - Control bit 0 selects thread privilege
// - Control bit 1 selects the stack
// - Stack select zero while in handler mode; control bit 1 is not cleared when an EXC write enters handler mode
`include "cms_defs.vh"

module cms_core_regs (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg         handler_mode,
  output reg         user_level,
  output reg         proc_sp_active,
  output reg  [31:0] stack_pointer,
  output reg  [31:0] program_counter,
  output reg         fault_pulse,
  output reg         irq_accept
);

  // Register array of the 13 general registers; stack banks held separately
  reg  [31:0] gpr_reg [0:`CMS_NUM_GPR-1];
  reg  [31:0] main_sp_reg;
  reg  [31:0] proc_sp_reg;
  reg  [31:0] link_reg;
  reg  [31:0] pc_reg;
  reg  [31:0] app_reg;
  reg  [8:0]  exc_num_reg;
  reg  [31:0] exe_reg;
  reg         priority_mask_bit_reg;
  reg         fltmask_reg;
  reg  [8:0]  base_priority_threshold_reg;
  reg  [1:0]  ctrl_reg;
  // Software-driven core stimulus: access attributes and pending irq
  reg  [7:0]  core_reg;
  reg  [8:0]  irq_num_reg;
  reg  [8:0]  irq_pri_reg;

  reg         dp_wr_reg;
  reg         dp_rd_reg;
  reg  [11:0] dp_addr_reg;

  wire addr_ok = hsel && hready && htrans == `CMS_HTRANS_NONSEQ &&
                 hsize == `CMS_HSIZE_WORD;
  wire in_handler = exc_num_reg != {`CMS_EXC_W{1'b0}};
  wire is_user = ~in_handler & ctrl_reg[`CMS_CTRL_USER];
  wire use_proc = ~in_handler & ctrl_reg[`CMS_CTRL_SPSEL];
  wire [31:0] sp_view = (use_proc ? proc_sp_reg : main_sp_reg)
                        & `CMS_SP_ALIGN;
  wire [31:0] psr_view = (app_reg & `CMS_APP_MASK) |
                         {23'h000000, exc_num_reg} |
                         (exe_reg & `CMS_EXE_MASK) |
                         (32'h00000001 << `CMS_TBIT);

  // Core request fields: bit0 user-side access to special register,
  // bit1 sixteen-bit encoding, bit2 call strobe, bits7:3 reg index
  wire        acc_special = core_reg[0];
  wire        enc16       = core_reg[1];
  wire        call_req    = core_reg[2];
  wire [4:0]  acc_idx     = core_reg[7:3];

  wire spec_addr = dp_addr_reg >= `CMS_ADDR_PSR &&
                   dp_addr_reg <= `CMS_ADDR_CTRL;
  wire user_block = dp_wr_reg & is_user & spec_addr;
  wire tbit_clr = dp_wr_reg & ~user_block &
                  (dp_addr_reg == `CMS_ADDR_PSR ||
                   dp_addr_reg == `CMS_ADDR_EXE) &
                  ~hwdata[`CMS_TBIT];
  wire core_fault = (is_user & acc_special) |
                    (enc16 & acc_idx >= `CMS_IDX_HI_FIRST &&
                     acc_idx < `CMS_IDX_SP);
  wire wr_ok = dp_wr_reg & ~user_block;

  // Masking priority: NMI beats everything, hard fault beats priority_mask_bit
  reg irq_ok;
  always @* begin
    irq_ok = irq_num_reg != {`CMS_EXC_W{1'b0}};
    if (fltmask_reg && irq_num_reg != `CMS_EXC_NMI)
      irq_ok = 1'b0;
    if (priority_mask_bit_reg && irq_num_reg != `CMS_EXC_NMI &&
        irq_num_reg != `CMS_EXC_HARD)
      irq_ok = 1'b0;
    if (base_priority_threshold_reg != {`CMS_BP_W{1'b0}} &&
        irq_pri_reg >= base_priority_threshold_reg &&
        irq_num_reg != `CMS_EXC_NMI &&
        irq_num_reg != `CMS_EXC_HARD)
      irq_ok = 1'b0;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg   <= 1'b0;
      dp_rd_reg   <= 1'b0;
      dp_addr_reg <= 12'h000;
    end else if (hready) begin
      dp_wr_reg   <= addr_ok & hwrite;
      dp_rd_reg   <= addr_ok & ~hwrite;
      dp_addr_reg <= haddr;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `CMS_NUM_GPR; gi = gi + 1) begin : g_gpr
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          gpr_reg[gi] <= 32'h00000000;
        end else if (wr_ok &&
                     dp_addr_reg == `CMS_ADDR_GPR_BASE + gi * 4) begin
          gpr_reg[gi] <= hwdata;
        end
      end
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_sp_reg <= 32'h00000000;
      proc_sp_reg <= 32'h00000000;
      link_reg    <= 32'h00000000;
      pc_reg      <= 32'h00000000;
      app_reg     <= 32'h00000000;
      exc_num_reg <= 9'h000;
      exe_reg     <= 32'h00000000;
      priority_mask_bit_reg <= 1'b0;
      fltmask_reg <= 1'b0;
      base_priority_threshold_reg <= 9'h000;
      ctrl_reg    <= 2'h0;
      core_reg    <= 8'h00;
      irq_num_reg <= 9'h000;
      irq_pri_reg <= 9'h000;
    end else begin
      if (call_req) begin
        link_reg <= pc_reg & `CMS_PC_ALIGN;
        core_reg[2] <= 1'b0;
      end
      if (irq_ok && !in_handler) begin
        exc_num_reg <= irq_num_reg;
        irq_num_reg <= 9'h000;
        ctrl_reg[`CMS_CTRL_SPSEL] <= 1'b0;
      end
      if (wr_ok) begin
        case (dp_addr_reg)
          `CMS_ADDR_MAIN_SP: main_sp_reg <= hwdata & `CMS_SP_ALIGN;
          `CMS_ADDR_PROC_SP: proc_sp_reg <= hwdata & `CMS_SP_ALIGN;
          `CMS_ADDR_LINK:    link_reg <= hwdata;
          `CMS_ADDR_PC:      pc_reg <= hwdata & `CMS_PC_ALIGN;
          `CMS_ADDR_PSR: begin
            app_reg <= hwdata & `CMS_APP_MASK;
            exe_reg <= hwdata & `CMS_EXE_MASK;
          end
          `CMS_ADDR_APP:     app_reg <= hwdata & `CMS_APP_MASK;
          `CMS_ADDR_EXE:     exe_reg <= hwdata & `CMS_EXE_MASK;
          `CMS_ADDR_PRIORITY_MASK_BIT: priority_mask_bit_reg <= hwdata[0];
          `CMS_ADDR_FLTMASK: fltmask_reg <= hwdata[0];
          `CMS_ADDR_BASE_PRIORITY_THRESHOLD: base_priority_threshold_reg <= hwdata[8:0];
          `CMS_ADDR_CTRL: begin
            ctrl_reg[`CMS_CTRL_USER] <= hwdata[0];
            // Handler mode has no alternate stack
            ctrl_reg[`CMS_CTRL_SPSEL] <= hwdata[1] &
                                         ~in_handler;
          end
          `CMS_ADDR_CORE:    core_reg <= hwdata[7:0];
          // Writing the exception number ends or starts service
          `CMS_ADDR_EXC:     exc_num_reg <= hwdata[8:0];
          `CMS_ADDR_IRQ: begin
            irq_num_reg <= hwdata[8:0];
            irq_pri_reg <= hwdata[24:16];
          end
          default: ;
        endcase
      end
    end
  end

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (dp_addr_reg < `CMS_ADDR_MAIN_SP)
      rd_mux = gpr_reg[dp_addr_reg[5:2]];
    case (dp_addr_reg)
      `CMS_ADDR_MAIN_SP: rd_mux = main_sp_reg & `CMS_SP_ALIGN;
      `CMS_ADDR_PROC_SP: rd_mux = proc_sp_reg & `CMS_SP_ALIGN;
      `CMS_ADDR_LINK:    rd_mux = link_reg;
      `CMS_ADDR_PC:      rd_mux = pc_reg & `CMS_PC_ALIGN;
      `CMS_ADDR_PSR:     rd_mux = psr_view;
      `CMS_ADDR_APP:     rd_mux = app_reg & `CMS_APP_MASK;
      `CMS_ADDR_INT:     rd_mux = {23'h000000, exc_num_reg};
      `CMS_ADDR_EXE:     rd_mux = (exe_reg & `CMS_EXE_MASK) |
                                  (32'h00000001 << `CMS_TBIT);
      `CMS_ADDR_PRIORITY_MASK_BIT: rd_mux = {31'h00000000, priority_mask_bit_reg};
      `CMS_ADDR_FLTMASK: rd_mux = {31'h00000000, fltmask_reg};
      `CMS_ADDR_BASE_PRIORITY_THRESHOLD: rd_mux = {23'h000000, base_priority_threshold_reg};
      `CMS_ADDR_CTRL:    rd_mux = {30'h00000000, ctrl_reg};
      `CMS_ADDR_CORE:    rd_mux = {24'h000000, core_reg};
      `CMS_ADDR_EXC:     rd_mux = {23'h000000, exc_num_reg};
      `CMS_ADDR_CALL:    rd_mux = link_reg;
      `CMS_ADDR_STATUS:  rd_mux = {27'h0000000, irq_ok, use_proc,
                                  is_user, in_handler, 1'b1};
      default: ;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata          <= 32'h00000000;
      hreadyout       <= 1'b1;
      hresp           <= 1'b0;
      handler_mode    <= 1'b0;
      user_level      <= 1'b0;
      proc_sp_active  <= 1'b0;
      stack_pointer   <= 32'h00000000;
      program_counter <= 32'h00000000;
      fault_pulse     <= 1'b0;
      irq_accept      <= 1'b0;
    end else begin
      // One wait state on reads: rd_mux is registered into hrdata before
      // the data phase ends, so the master takes a settled word
      hreadyout       <= ~(addr_ok & ~hwrite);
      hresp           <= 1'b0;
      hrdata          <= (addr_ok & ~hwrite) ? 32'h00000000 : hrdata;
      if (dp_rd_reg)
        hrdata <= rd_mux;
      handler_mode    <= in_handler;
      user_level      <= is_user;
      proc_sp_active  <= use_proc;
      stack_pointer   <= sp_view;
      program_counter <= pc_reg & `CMS_PC_ALIGN;
      fault_pulse     <= user_block | tbit_clr | core_fault;
      irq_accept      <= irq_ok & ~in_handler;
    end
  end

endmodule

//--- cms_chk.sv
`timescale 1ns/1ps
module cms_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [11:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [2:0]  hsize,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire        handler_mode,
  input wire        user_level,
  input wire        proc_sp_active,
  input wire [31:0] stack_pointer,
  input wire [31:0] program_counter,
  input wire        fault_pulse,
  input wire        irq_accept
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // User-level write aimed at the status, mask or control words
  wire uwr = hsel && hready && htrans == 2'h2 && hsize == 3'h2 && hwrite
    && user_level && haddr >= 12'h050 && haddr <= 12'h06C;
  a_priv_handler: assert property (handler_mode |-> !user_level)
    else $error("user level seen in handler mode");
  a_handler_stack: assert property (handler_mode |-> !proc_sp_active)
    else $error("process stack used in handler mode");
  a_sp_align: assert property (stack_pointer[1:0] == 2'b00)
    else $error("stack pointer not word aligned");
  a_pc_align: assert property (program_counter[0] == 1'b0)
    else $error("program counter bit 0 set");
  a_user_fault: assert property (uwr |-> ##[1:3] fault_pulse)
    else $error("blocked user write raised no fault");
  a_ctrl_locked: assert property (uwr && haddr == 12'h06C |-> ##2 user_level)
    else $error("user write changed privilege");
  a_reset_state: assert property ($rose(hresetn) |->
    !handler_mode && !user_level && !proc_sp_active)
    else $error("wrong mode after reset");
  a_thread_accept: assert property (handler_mode && $past(handler_mode)
    |-> !irq_accept)
    else $error("interrupt accepted in handler mode");
  a_bus_okay: assert property (!hresp)
    else $error("bus error response");
  a_wait_short: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  c_fault: cover property (uwr ##[1:3] fault_pulse);
  c_handler: cover property (handler_mode);
  c_accept: cover property (irq_accept);
  c_proc_sp: cover property (proc_sp_active);
endmodule
bind cms_core_regs cms_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hready, .hreadyout, .hresp, .handler_mode, .user_level,
  .proc_sp_active, .stack_pointer, .program_counter, .fault_pulse,
  .irq_accept);

//--- tb_top.sv
`timescale 1ns/1ps
`include "cms_defs.vh"
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, fseen, aseen;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, rd, v, w, seed;
  logic [31:0] gpr [13];
  wire  [31:0] hrdata, stack_pointer, program_counter;
  wire         hreadyout, hresp, handler_mode, user_level;
  wire         proc_sp_active, fault_pulse, irq_accept;
  int          bad_count, n_checks;
  cms_core_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .handler_mode(handler_mode),
    .user_level(user_level), .proc_sp_active(proc_sp_active),
    .stack_pointer(stack_pointer), .program_counter(program_counter),
    .fault_pulse(fault_pulse), .irq_accept(irq_accept));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // A fault is a single-cycle pulse, so latch it for later inspection
  always @(posedge hclk) if (fault_pulse === 1'b1) fseen <= 1'b1;
  always @(posedge hclk) if (irq_accept === 1'b1) aseen <= 1'b1;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic acc(logic pm, fm, logic [8:0] bp, num, pr);
    if (num == `CMS_EXC_NMI) return 1'b1;
    if (fm) return 1'b0;
    if (num == `CMS_EXC_HARD) return 1'b1;
    return !pm && !(bp != 9'h0 && pr >= bp);
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) bad_count++;
  endtask
  // Read data is taken at the edge that ends the data phase
  task automatic bus(input logic [11:0] a, input logic we, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= `CMS_HTRANS_NONSEQ;
    hwrite <= we;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask
  task automatic st();
    repeat (3) @(posedge hclk);
  endtask
  task automatic irq(input logic pm, fm, input logic [8:0] bp, num, pr,
                     input logic hm);
    aseen <= 1'b0;
    bus(`CMS_ADDR_PRIORITY_MASK_BIT, 1'b1, {31'h0, pm});
    bus(`CMS_ADDR_FLTMASK, 1'b1, {31'h0, fm});
    bus(`CMS_ADDR_BASE_PRIORITY_THRESHOLD, 1'b1, {23'h0, bp});
    bus(`CMS_ADDR_IRQ, 1'b1, {7'h0, pr, 7'h0, num});
    st();
    chk(aseen, acc(pm, fm, bp, num, pr) && !hm);
    // Drop any pending request, then leave service if it was taken
    bus(`CMS_ADDR_IRQ, 1'b1, 32'h0);
    if (!hm) bus(`CMS_ADDR_EXC, 1'b1, 32'h0);
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    test_done();
  end
  initial begin
    seed = 32'd1823;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `CMS_HSIZE_WORD;
    hwdata = 32'h0;
    fseen = 1'b0;
    aseen = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({handler_mode, user_level, proc_sp_active}, 32'h0);
    for (int i = 0; i < 4; i++) rc(12'(12'h060 + 4 * i), 32'h0);
    for (int i = 0; i < 13; i++) begin
      gpr[i] = rnd();
      bus(12'(4 * i), 1'b1, gpr[i]);
    end
    for (int i = 0; i < 13; i++) rc(12'(4 * i), gpr[i]);
    v = rnd() | 32'h3;
    w = rnd() | 32'h1;
    bus(`CMS_ADDR_MAIN_SP, 1'b1, v);
    bus(`CMS_ADDR_PROC_SP, 1'b1, w);
    st();
    chk(stack_pointer, v & `CMS_SP_ALIGN);
    bus(`CMS_ADDR_CTRL, 1'b1, 32'h3);
    st();
    chk({user_level, proc_sp_active}, 32'h3);
    chk(stack_pointer, w & `CMS_SP_ALIGN);
    fseen <= 1'b0;
    bus(`CMS_ADDR_PRIORITY_MASK_BIT, 1'b1, 32'h1);
    bus(`CMS_ADDR_CTRL, 1'b1, 32'h0);
    st();
    chk(fseen, 32'h1);
    rc(`CMS_ADDR_PRIORITY_MASK_BIT, 32'h0);
    bus(`CMS_ADDR_EXC, 1'b1, 32'h25);
    st();
    chk({handler_mode, user_level, proc_sp_active}, 32'h4);
    chk(stack_pointer, v & `CMS_SP_ALIGN);
    rc(`CMS_ADDR_INT, 32'h25);
    irq(1'b0, 1'b0, 9'h0, 9'h020, 9'h001, 1'b1);
    bus(`CMS_ADDR_CTRL, 1'b1, 32'h0);
    bus(`CMS_ADDR_EXC, 1'b1, 32'h0);
    st();
    chk({handler_mode, user_level}, 32'h0);
    v = rnd() | 32'h1;
    bus(`CMS_ADDR_PC, 1'b1, v);
    st();
    chk(program_counter, v & `CMS_PC_ALIGN);
    v = rnd();
    bus(`CMS_ADDR_PSR, 1'b1, v | 32'h01000000);
    rc(`CMS_ADDR_APP, v & `CMS_APP_MASK);
    rc(`CMS_ADDR_EXE, v & `CMS_EXE_MASK | 32'h01000000);
    fseen <= 1'b0;
    bus(`CMS_ADDR_EXE, 1'b1, 32'h0);
    bus(`CMS_ADDR_EXE, 1'b0, 32'h0);
    chk(rd & 32'h01000000, 32'h01000000);
    chk(fseen, 32'h1);
    irq(1'b0, 1'b0, 9'h040, 9'h020, 9'h040, 1'b0);
    irq(1'b0, 1'b0, 9'h040, 9'h020, 9'h03F, 1'b0);
    irq(1'b1, 1'b0, 9'h0, `CMS_EXC_HARD, 9'h1FF, 1'b0);
    irq(1'b0, 1'b1, 9'h0, `CMS_EXC_HARD, 9'h0, 1'b0);
    irq(1'b1, 1'b1, 9'h001, `CMS_EXC_NMI, 9'h1FF, 1'b0);
    repeat (40) begin
      v = rnd();
      w = v[13:12] == 2'h0 ? `CMS_EXC_NMI : v[13:12] == 2'h1 ?
          `CMS_EXC_HARD : {4'h1, v[18:14]};
      irq(v[0], v[1], v[2] ? v[11:3] : 9'h0, w[8:0], v[27:19], 1'b0);
    end
    test_done();
  end
endmodule
